// >>> src/rng_host_port.sv
// Purpose: host port, flags and bit strobe of a random number generator
// Assumes: strobes arrive asynchronously; run-up results on ref_clk
// Notes:   read strobes shorter than four clocks may raise a bus error
`timescale 1ns/1ns
`default_nettype none
`include "rng_cfg.svh"
module rng_host_port
	import rng_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       chipSelectN,
	input  wire logic       readStrobeN,
	input  wire logic       writeStrobeN,
	input  wire logic       masterResetN,
	input  wire logic [2:0] regSelect,
	input  wire logic [7:0] hostBusIn,
	output logic      [7:0] hostBusOut,
	output logic            hostBusOeN,
	input  wire logic       slowSamplingClock,
	input  wire logic       randomBit,
	input  wire logic       runUpPassed,
	input  wire logic       runUpFail,
	input  wire logic       matchEvent,
	input  wire logic       patternLoad,
	input  wire logic [3:0] patternIn,
	output logic            newBitStrobe,
	output logic            numberReadyN,
	output logic            alarmN,
	output logic            runUpEnable,
	output logic            freeRun,
	output logic            alarmTest,
	output logic [7:0]      lowerLimit,
	output logic [7:0]      upperLimit
);
	// ==========================================
	// synchronisers
	logic [15:0] syncOut;
	logic        csS, rdS, wrS, mrS, slowS, slowPrev;
	logic [2:0]  selS;
	rng_byte_t   busS;
	rng_sync #(.WIDTH(16)) u_sync (
		.ref_clk (ref_clk),
		.rstVal  (16'h003F),
		.sys_rst (sys_rst),
		.asyncIn ({slowSamplingClock, regSelect, hostBusIn, masterResetN, writeStrobeN,
			readStrobeN, chipSelectN}),
		.syncOut (syncOut)
	);
	assign csS   = syncOut[0];
	assign rdS   = syncOut[1];
	assign wrS   = syncOut[2];
	assign mrS   = syncOut[3];
	assign busS  = syncOut[11:4];
	assign selS  = syncOut[14:12];
	assign slowS = syncOut[15];

	// ==========================================
	// state
	rng_acc_t  accState;
	rng_byte_t wrData, echo, directAccess, eventCount, byteCounter;
	rng_idx_t  fillIdx, readIdx;
	logic [2:0] bitIdx;
	logic [4:0] slowCnt;
	logic [3:0] pattern;
	logic intReset, storeFull, busError, runFailed, alarm, ready;
	logic mrHit, clearAll, rdDone, wrCommit, storeRead, lastRead, busErrSet, bitTick;
	rng_mem_if mem ();

	rng_byte_store u_store (
		.ref_clk (ref_clk),
		.mem     (mem.store)
	);

	function automatic rng_byte_t regMux(input logic [2:0] sel, input rng_byte_t store,
		input rng_byte_t status);
		case (sel)
			`RNG_ADDR_STORE:   regMux = store;
			`RNG_ADDR_STATUS:  regMux = status;
			`RNG_ADDR_EVENT:   regMux = eventCount;
			`RNG_ADDR_PATTERN: regMux = {4'h0, pattern};
			`RNG_ADDR_LOWER:   regMux = lowerLimit;
			`RNG_ADDR_UPPER:   regMux = upperLimit;
			`RNG_ADDR_COUNT:   regMux = byteCounter;
			default:           regMux = directAccess;
		endcase
	endfunction

	rng_byte_t statusWord;
	always_comb begin
		statusWord = 8'h00;
		statusWord[`RNG_ST_READY_N]  = numberReadyN;
		statusWord[`RNG_ST_INT_RST]  = intReset;
		statusWord[`RNG_ST_FREE_RUN] = freeRun;
		statusWord[`RNG_ST_ALM_TEST] = alarmTest;
		statusWord[`RNG_ST_ALARM]    = alarm;
		statusWord[`RNG_ST_RUN_FAIL] = runFailed;
		statusWord[`RNG_ST_BUS_ERR]  = busError;
	end

	assign mrHit     = !csS && !mrS;
	assign clearAll  = mrHit || intReset;
	assign rdDone    = (accState == ACC_READ) && (rdS || csS);
	assign wrCommit  = (accState == ACC_WRITE) && wrS && !csS;
	assign storeRead = rdDone && (selS == `RNG_ADDR_STORE);
	assign lastRead  = storeRead && (readIdx == `RNG_LAST_BYTE);
	assign busErrSet = storeRead && (echo != hostBusOut);
	assign bitTick   = slowS && !slowPrev && (slowCnt == `RNG_HALF_M1);

	// ==========================================
	// host access sequencing
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			accState <= ACC_IDLE;
		end else begin
			case (accState)
				ACC_IDLE: begin
					if (!csS && !rdS && wrS) begin
						accState <= ACC_READ;
					end else if (!csS && !wrS && rdS) begin
						accState <= ACC_WRITE;
					end
				end
				ACC_READ:  if (rdS || csS) accState <= ACC_IDLE;
				ACC_WRITE: if (wrS || csS) accState <= ACC_IDLE;
				default:   accState <= ACC_IDLE;
			endcase
		end
	end

	assign hostBusOeN = !((accState == ACC_READ) && !csS && !rdS);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hostBusOut <= 8'h00;
			echo       <= 8'h00;
			wrData     <= 8'h00;
		end else begin
			if (accState == ACC_IDLE && !csS && !rdS) begin
				hostBusOut <= regMux(selS, mem.rdData, statusWord);
			end
			echo   <= busS;
			wrData <= busS;
		end
	end

	// ==========================================
	// writable registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lowerLimit <= `RNG_LOWER_RST;
			upperLimit <= `RNG_UPPER_RST;
			pattern    <= `RNG_PATTERN_RST;
		end else begin
			if (wrCommit && selS == `RNG_ADDR_LOWER) lowerLimit <= wrData;
			if (wrCommit && selS == `RNG_ADDR_UPPER) upperLimit <= wrData;
			if (patternLoad) pattern <= patternIn;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || mrHit) begin
			intReset  <= 1'b0;
			freeRun   <= 1'b0;
			alarmTest <= 1'b0;
		end else if (wrCommit && selS == `RNG_ADDR_STATUS) begin
			intReset  <= wrData[`RNG_ST_INT_RST];
			freeRun   <= wrData[`RNG_ST_FREE_RUN];
			alarmTest <= wrData[`RNG_ST_ALM_TEST];
		end
	end

	// ==========================================
	// bit strobe and store filling
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			slowPrev     <= 1'b0;
			slowCnt      <= 5'h00;
			newBitStrobe <= 1'b0;
		end else begin
			slowPrev <= slowS;
			if (slowS && !slowPrev) begin
				slowCnt      <= slowCnt + 5'h01;
				newBitStrobe <= (slowCnt >= `RNG_HALF_M1) && (slowCnt != 5'h1F);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || clearAll) begin
			directAccess <= 8'h00;
			bitIdx       <= 3'h0;
			fillIdx      <= 7'h00;
			storeFull    <= 1'b0;
		end else begin
			if (lastRead) begin
				storeFull <= 1'b0;
			end
			if (bitTick && runUpEnable) begin
				directAccess <= {directAccess[6:0], randomBit};
				bitIdx       <= bitIdx + 3'h1;
				if (bitIdx == 3'h7) begin
					if (fillIdx == `RNG_LAST_BYTE) begin
						fillIdx   <= 7'h00;
						storeFull <= 1'b1;
					end else begin
						fillIdx <= fillIdx + 7'h01;
					end
				end
			end
		end
	end

	assign mem.wrEn   = bitTick && runUpEnable && (bitIdx == 3'h7);
	assign mem.wrAddr = fillIdx;
	assign mem.wrData = {directAccess[6:0], randomBit};
	assign mem.rdAddr = readIdx;
	assign runUpEnable = !busError && !intReset && (readIdx == 7'h00)
		&& (freeRun || !storeFull);

	// ==========================================
	// store reading and counters
	always_ff @(posedge ref_clk) begin
		if (sys_rst || clearAll) begin
			readIdx     <= 7'h00;
			byteCounter <= 8'h00;
		end else if (storeRead) begin
			readIdx     <= lastRead ? 7'h00 : readIdx + 7'h01;
			byteCounter <= lastRead ? 8'h00 : byteCounter + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || clearAll) begin
			eventCount <= 8'h00;
		end else if (matchEvent && runUpEnable) begin
			eventCount <= eventCount + 8'h01;
		end
	end

	// ==========================================
	// flags
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			busError  <= 1'b0;
			runFailed <= 1'b0;
			alarm     <= 1'b0;
		end else begin
			if (busErrSet) busError <= 1'b1;
			else if (mrHit) busError <= 1'b0;
			if (runUpFail) runFailed <= 1'b1;
			else if (mrHit) runFailed <= 1'b0;
			if (busErrSet || runUpFail) alarm <= 1'b1;
			else if (mrHit) alarm <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ready <= 1'b0;
		end else begin
			ready <= storeFull && runUpPassed && !busError && !clearAll;
		end
	end

	assign numberReadyN = !ready;
	assign alarmN       = !alarm;

	// ==========================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	chk_bus_released: assert property (csS |-> hostBusOeN)
		else $error("bus driven without chip select");
	chk_read_drive: assert property ((accState == ACC_IDLE) && !csS && !rdS && wrS
		|=> csS || rdS || !hostBusOeN)
		else $error("read data not driven");
	chk_mr_clears: assert property (mrHit |=> !storeFull && eventCount == 8'h00
		&& byteCounter == 8'h00 && !freeRun && !alarmTest)
		else $error("master reset left state behind");
	chk_limits_kept: assert property (mrHit && !wrCommit |=> $stable(lowerLimit)
		&& $stable(upperLimit))
		else $error("limits lost on master reset");
	chk_bit_entry: assert property (bitTick && runUpEnable && !clearAll
		|=> directAccess[0] == $past(randomBit) && $rose(newBitStrobe))
		else $error("new bit not shifted on strobe edge");
	chk_ready_drop: assert property (lastRead && !clearAll |-> ##2 numberReadyN)
		else $error("ready held after last store read");
	chk_alarm_set: assert property (busErrSet || runUpFail |=> !alarmN [*3])
		else $error("alarm missing after fault");
	chk_alarm_sticky: assert property (alarm && !mrHit |=> alarm)
		else $error("alarm cleared without master reset");
	chk_write_capture: assert property (wrCommit && selS == `RNG_ADDR_UPPER
		|=> upperLimit == $past(wrData))
		else $error("write not captured");
endmodule // rng_host_port
`default_nettype wire

// >>> src/rng_cfg.svh
// Purpose: constants of the random number host port
// Assumes: included by bare name
// Notes:   offsets are register select codes
`ifndef RNG_CFG_SVH
`define RNG_CFG_SVH
// ==========================================
// register select codes
`define RNG_ADDR_STORE   3'h0
`define RNG_ADDR_STATUS  3'h1
`define RNG_ADDR_EVENT   3'h2
`define RNG_ADDR_PATTERN 3'h3
`define RNG_ADDR_LOWER   3'h4
`define RNG_ADDR_UPPER   3'h5
`define RNG_ADDR_COUNT   3'h6
`define RNG_ADDR_DIRECT  3'h7
// ==========================================
// status/command bit positions
`define RNG_ST_READY_N   0
`define RNG_ST_INT_RST   1
`define RNG_ST_FREE_RUN  2
`define RNG_ST_ALM_TEST  3
`define RNG_ST_ALARM     4
`define RNG_ST_RUN_FAIL  5
`define RNG_ST_BUS_ERR   6
// ==========================================
// sizes and reset values
`define RNG_STORE_BITS   536
`define RNG_STORE_BYTES  67
`define RNG_LAST_BYTE    7'h42
`define RNG_LOWER_RST    8'h00
`define RNG_UPPER_RST    8'hFF
`define RNG_PATTERN_RST  4'h0
// ==========================================
// timing: slow clock periods per strobe period
`define RNG_SLOW_PER_BIT 32
`define RNG_HALF_M1      5'h0F
`endif

// >>> src/rng_pkg.sv
// Purpose: shared types of the random number host port
// Assumes: nothing
// Notes:   constants live in rng_cfg.svh
package rng_pkg;
	typedef enum logic [1:0] {ACC_IDLE, ACC_READ, ACC_WRITE} rng_acc_t;
	typedef logic [7:0] rng_byte_t;
	typedef logic [6:0] rng_idx_t;
endpackage

// >>> src/rng_mem_if.sv
// Purpose: port group between port logic and byte store
// Assumes: one clock
// Notes:   read data registered in the store
`timescale 1ns/1ns
`default_nettype none
interface rng_mem_if;
	import rng_pkg::*;
	logic      wrEn;
	rng_idx_t  wrAddr;
	rng_byte_t wrData;
	rng_idx_t  rdAddr;
	rng_byte_t rdData;
	modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
	modport user  (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
endinterface
`default_nettype wire

// >>> src/rng_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: levels only
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module rng_sync
	import rng_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic [WIDTH-1:0] rstVal,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stage1  <= rstVal;
			syncOut <= rstVal;
		end else begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule // rng_sync
`default_nettype wire

// >>> src/rng_byte_store.sv
// Purpose: random byte store memory
// Assumes: one write and one read port
// Notes:   read data come from a register
`timescale 1ns/1ns
`default_nettype none
`include "rng_cfg.svh"
module rng_byte_store
	import rng_pkg::*;
(
	input  wire logic ref_clk,
	rng_mem_if.store  mem
);
	rng_byte_t bytes [0:`RNG_STORE_BYTES-1];
	always_ff @(posedge ref_clk) begin
		if (mem.wrEn) begin
			bytes[mem.wrAddr] <= mem.wrData;
		end
	end
	always_ff @(posedge ref_clk) begin
		mem.rdData <= bytes[mem.rdAddr];
	end
endmodule // rng_byte_store
`default_nettype wire

// >>> verif/rng_host_model.sv
// Purpose: host processor model on the parallel data bus
// Assumes: strobes held far longer than the input synchronisers
// Notes:   a released bus shows the inverse of its last level
`timescale 1ns/1ns
`default_nettype none
module rng_host_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] hostBusOut,
	input  wire logic       hostBusOeN,
	input  wire logic       busFault,
	output logic            chipSelectN,
	output logic            readStrobeN,
	output logic            writeStrobeN,
	output logic            masterResetN,
	output logic      [2:0] regSelect,
	output logic      [7:0] hostBusIn
);
	logic       hostDrive = 1'b0;
	logic [7:0] hostData  = 8'h00;
	logic [7:0] lastLevel = 8'h00;
	logic [7:0] busWire;
	// ==========================================
	// wire resolution
	assign busWire   = !hostBusOeN ? hostBusOut : (hostDrive ? hostData : ~lastLevel);
	// fault injection: contention on line 0
	assign hostBusIn = busWire ^ {7'h00, busFault};
	always @(posedge ref_clk) begin
		if (!hostBusOeN || hostDrive) lastLevel <= busWire;
	end
	initial begin
		chipSelectN  = 1'b1;
		readStrobeN  = 1'b1;
		writeStrobeN = 1'b1;
		masterResetN = 1'b1;
		regSelect    = 3'h0;
	end
	// ==========================================
	// bus cycles
	task automatic read_reg(input logic [2:0] addr, input logic sel, output logic [7:0] data);
		@(posedge ref_clk);
		regSelect   <= addr;
		chipSelectN <= ~sel;
		readStrobeN <= 1'b0;
		repeat (8) @(posedge ref_clk);
		data = busWire;
		readStrobeN <= 1'b1;
		chipSelectN <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic write_reg(input logic [2:0] addr, input logic sel, input logic [7:0] data);
		@(posedge ref_clk);
		regSelect    <= addr;
		hostData     <= data;
		hostDrive    <= 1'b1;
		chipSelectN  <= ~sel;
		writeStrobeN <= 1'b0;
		repeat (6) @(posedge ref_clk);
		writeStrobeN <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chipSelectN <= 1'b1;
		hostDrive   <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic mreset(input logic sel);
		@(posedge ref_clk);
		chipSelectN  <= ~sel;
		masterResetN <= 1'b0;
		repeat (4) @(posedge ref_clk);
		masterResetN <= 1'b1;
		chipSelectN  <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
endmodule // rng_host_model
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self-checking bench of the random number host port
// Assumes: slow sampling clock of four reference periods
// Notes:   store filled with constant ones
`timescale 1ns/1ns
`default_nettype none
module tb;
	import rng_pkg::*;
	typedef struct packed {logic [2:0] addr; rng_byte_t wr; rng_byte_t exp;} rng_row_t;
	localparam int SLOW_NS = 40;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic chipSelectN, readStrobeN, writeStrobeN, masterResetN, hostBusOeN, busFault = 1'b0;
	logic [2:0] regSelect;
	logic [7:0] hostBusIn, hostBusOut, lowerLimit, upperLimit, d, oeCount = 8'h00, oeBase;
	logic slowSamplingClock = 1'b0, slowDiv = 1'b0, slowRun = 1'b0;
	logic randomBit = 1'b0, runUpPassed = 1'b0, runUpFail = 1'b0, matchEvent = 1'b0;
	logic patternLoad = 1'b0, newBitStrobe, numberReadyN, alarmN;
	logic runUpEnable, freeRun, alarmTest;
	logic [3:0] patternIn = 4'h0;
	int nFail = 0, cmpCount = 0, i;
	time tStart;
	rng_row_t rows [6] = '{'{3'h4, 8'h5A, 8'h5A}, '{3'h5, 8'hC3, 8'hC3},
		'{3'h3, 8'hFF, 8'h0A}, '{3'h2, 8'hFF, 8'h03}, '{3'h6, 8'hFF, 8'h00},
		'{3'h1, 8'h04, 8'h05}};
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (hostBusOeN !== 1'b1) oeCount <= oeCount + 8'h01;
		if (slowRun) slowDiv <= ~slowDiv;
		if (slowRun && slowDiv) slowSamplingClock <= ~slowSamplingClock;
	end
	rng_host_port u_rng_host_port (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.chipSelectN(chipSelectN), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
		.masterResetN(masterResetN), .regSelect(regSelect), .hostBusIn(hostBusIn),
		.hostBusOut(hostBusOut), .hostBusOeN(hostBusOeN), .slowSamplingClock(slowSamplingClock),
		.randomBit(randomBit), .runUpPassed(runUpPassed), .runUpFail(runUpFail),
		.matchEvent(matchEvent), .patternLoad(patternLoad), .patternIn(patternIn),
		.newBitStrobe(newBitStrobe), .numberReadyN(numberReadyN), .alarmN(alarmN),
		.runUpEnable(runUpEnable), .freeRun(freeRun), .alarmTest(alarmTest),
		.lowerLimit(lowerLimit), .upperLimit(upperLimit));
	rng_host_model u_rng_host_model (.ref_clk(ref_clk), .hostBusOut(hostBusOut),
		.hostBusOeN(hostBusOeN), .busFault(busFault), .chipSelectN(chipSelectN),
		.readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
		.masterResetN(masterResetN), .regSelect(regSelect), .hostBusIn(hostBusIn));
	// ==========================================
	// compare and report
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nFail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic expect_reg(input logic [2:0] addr, input logic [7:0] exp);
		u_rng_host_model.read_reg(addr, 1'b1, d);
		check("register", d, exp);
	endtask
	task automatic printVerdict();
		$display("comparisons %0d mismatches %0d", cmpCount, nFail);
		if (nFail == 0 && cmpCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		nFail++;
		printVerdict();
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		patternIn <= 4'hA;
		patternLoad <= 1'b1;
		@(posedge ref_clk);
		patternLoad <= 1'b0;
		repeat (3) begin
			matchEvent <= 1'b1;
			@(posedge ref_clk);
			matchEvent <= 1'b0;
			@(posedge ref_clk);
		end
		for (i = 0; i < 6; i++) begin
			u_rng_host_model.write_reg(rows[i].addr, 1'b1, rows[i].wr);
			u_rng_host_model.read_reg(rows[i].addr, 1'b1, d);
			check("row", d, rows[i].exp);
		end
		$display("test register table done");
		oeBase = oeCount;
		u_rng_host_model.read_reg(3'h4, 1'b0, d);
		u_rng_host_model.write_reg(3'h4, 1'b0, 8'h00);
		u_rng_host_model.mreset(1'b0);
		check("oeCount", oeCount - oeBase, 8'h00);
		check("lowerLimit", lowerLimit, 8'h5A);
		check("freeRun", {7'h00, freeRun}, 8'h01);
		u_rng_host_model.mreset(1'b1);
		check("freeRun", {7'h00, freeRun}, 8'h00);
		check("upperLimit", upperLimit, 8'hC3);
		expect_reg(3'h2, 8'h00);
		expect_reg(3'h3, 8'h0A);
		expect_reg(3'h5, 8'hC3);
		expect_reg(3'h1, 8'h01);
		u_rng_host_model.write_reg(3'h1, 1'b1, 8'h0A);
		expect_reg(3'h1, 8'h0B);
		u_rng_host_model.write_reg(3'h1, 1'b1, 8'h08);
		check("alarmTest", {7'h00, alarmTest}, 8'h01);
		u_rng_host_model.mreset(1'b1);
		check("alarmTest", {7'h00, alarmTest}, 8'h00);
		$display("test master reset done");
		runUpFail <= 1'b1;
		@(posedge ref_clk);
		runUpFail <= 1'b0;
		repeat (3) @(posedge ref_clk);
		expect_reg(3'h1, 8'h31);
		u_rng_host_model.write_reg(3'h1, 1'b1, 8'h00);
		check("alarmN", {7'h00, alarmN}, 8'h00);
		u_rng_host_model.mreset(1'b1);
		check("alarmN", {7'h00, alarmN}, 8'h01);
		$display("test alarm done");
		randomBit <= 1'b1;
		runUpPassed <= 1'b1;
		slowRun <= 1'b1;
		@(posedge newBitStrobe);
		tStart = $time;
		@(posedge newBitStrobe);
		check("strobePeriod", 8'(($time - tStart) / SLOW_NS), 8'h20);
		repeat (8) @(posedge newBitStrobe);
		expect_reg(3'h7, 8'hFF);
		for (i = 0; i < 80000 && numberReadyN !== 1'b0; i++) @(posedge ref_clk);
		check("numberReadyN", {7'h00, numberReadyN}, 8'h00);
		expect_reg(3'h1, 8'h00);
		for (i = 0; i < 67; i++) begin
			expect_reg(3'h0, 8'hFF);
			if (i == 65) expect_reg(3'h6, 8'h42);
			if (i == 65) check("numberReadyN", {7'h00, numberReadyN}, 8'h00);
		end
		repeat (2) @(posedge ref_clk);
		check("numberReadyN", {7'h00, numberReadyN}, 8'h01);
		$display("test fill and readout done");
		// store now holds written bytes, so the echo compare is defined
		busFault <= 1'b1;
		u_rng_host_model.read_reg(3'h0, 1'b1, d);
		busFault <= 1'b0;
		check("alarmN", {7'h00, alarmN}, 8'h00);
		check("runUpEnable", {7'h00, runUpEnable}, 8'h00);
		expect_reg(3'h1, 8'h51);
		u_rng_host_model.mreset(1'b1);
		$display("test bus error done");
		sys_rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		check("hostBusOeN", {7'h00, hostBusOeN}, 8'h01);
		check("numberReadyN", {7'h00, numberReadyN}, 8'h01);
		$display("test mid-run reset done");
		printVerdict();
	end
endmodule // tb
`default_nettype wire
